// [rtl/flash_dev_end.sv]
`timescale 1ns/10ps
// Summary of operation
// - Bus bytes map memory words little-endian
// - Read performs memory reads until data ready
// - Status flags cover the whole memory word
// - Pending posted write stalls reads with wait states
// - Memory access during program or erase returns error; register access does not
// - Bus write loads page buffer, selection or protection, never the array
// - Master sets control bits before each write
// - Idle write posts at once, write behind a pending posted write waits
// - Replay bit rewrites retained data, reads zero
// - No error for protected or locked sectors
// - Locks from index, all sectors start protected
// - Protection write takes bit 0 of data
// - Sector selection latches, cleared after erase
// - Erase sets targeted sectors or page ones
// - Master loads pulse then starts erase
// - Ready low during whole erase or program
// - Erase end sets done, restores start bit
// - Program clears bits where buffer holds zero
// - Master never reprograms a partly programmed word
// - Preset fills buffer with ones
// - Pulse counts system or reference clock cycles
// - Program starts by control write, then completes
// - Interrupt when pending and enabled bits overlap
module flash_dev_end #(
  parameter bit USE_REF_CLK = 1'b0,
  parameter int unsigned WR_LAT = 2,
  parameter logic [flash_pkg::SECT_N-1:0] LOCK_MASK = 32'hC0000000
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic timing_ref_in,
  output logic irq_out,
  output logic array_ready_out,
  flash_bus_if.dev bus
);

  // Post counter is four bits wide, so longer latencies cannot be served
  if (WR_LAT < 1 || WR_LAT > 15) begin : g_bad_lat
    $error("WR_LAT must be 1 to 15");
  end

  // ****************************************
  // State and storage
  // ****************************************
  flash_pkg::arr_state_t st_q;
  flash_pkg::arr_state_t st_d;
  logic [flash_pkg::DATA_W-1:0] mem_q [flash_pkg::WORDS];
  logic [flash_pkg::DATA_W-1:0] pbuf_q [flash_pkg::ROW_WORDS];
  logic [flash_pkg::CTRL_W-1:0] ctrl_q;
  logic [flash_pkg::CTRL_W-1:0] ctrl_d;
  logic [flash_pkg::PT_LEN_W:0] ptime_q;
  logic [flash_pkg::SECT_N-1:0] prot_q;
  logic [flash_pkg::SECT_N-1:0] sel_q;
  logic [flash_pkg::INT_W-1:0] int_st_q;
  logic [flash_pkg::INT_W-1:0] int_st_d;
  logic [flash_pkg::INT_W-1:0] int_en_q;
  logic [flash_pkg::INT_W-1:0] int_en_d;
  logic [12:0] waddr_q;
  logic [flash_pkg::DATA_W-1:0] wdata_q;
  logic [flash_pkg::PT_LEN_W-1:0] cnt_q;
  logic [3:0] post_q;
  logic ack_q;
  logic err_q;
  logic [flash_pkg::DATA_W-1:0] rdata_q;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;

  assign bus.ack = ack_q;
  assign bus.err = err_q;
  assign bus.rdata = rdata_q;

  // ****************************************
  // Bus decode
  // ****************************************
  // A request stays up until the master sees ack, so the ack cycle itself is not a new request
  wire take = bus.req && !ack_q;
  wire is_reg = bus.addr[flash_pkg::REG_SPACE_BIT];
  wire [11:0] ofs = {bus.addr[11:2], 2'b00};
  wire [12:0] word_idx = bus.addr[14:2];
  wire op_sel = ctrl_q[flash_pkg::CB_OP_SEL];
  wire variant = ctrl_q[flash_pkg::CB_VARIANT];
  wire enable = ctrl_q[flash_pkg::CB_ENABLE];
  wire rd_blocked = op_sel || variant;
  wire reg_take = take && is_reg;
  wire reg_wr = reg_take && bus.we;
  wire mem_err = take && !is_reg && (st_q == flash_pkg::ST_HV || (!bus.we && rd_blocked));
  wire mem_rd = take && !is_reg && !bus.we && !rd_blocked && st_q == flash_pkg::ST_IDLE;
  wire mem_wr = take && !is_reg && bus.we && st_q == flash_pkg::ST_IDLE;
  wire ack_d = reg_take || mem_err || mem_rd || mem_wr;
  wire ctrl_wr = reg_wr && ofs == flash_pkg::OFS_CTRL;
  wire replay = ctrl_wr && bus.wdata[flash_pkg::CB_REPLAY] && st_q == flash_pkg::ST_IDLE;

  // ****************************************
  // Pulse timing
  // ****************************************
  // Reference clock is slow against the system clock, so its rising edge is a tick
  wire ref_tick = USE_REF_CLK ? (ref_s2_q && !ref_s3_q) : 1'b1;
  wire pt_en = ptime_q[flash_pkg::PT_EN_BIT];
  wire [flash_pkg::PT_LEN_W-1:0] pt_len = ptime_q[flash_pkg::PT_LEN_W-1:0];
  wire [flash_pkg::PT_LEN_W-1:0] cnt_inc = cnt_q + 16'h0001;
  wire hv_start = ctrl_wr && st_q == flash_pkg::ST_IDLE && pt_en && bus.wdata[flash_pkg::CB_OP_SEL]
                  && bus.wdata[flash_pkg::CB_ENABLE] && !bus.wdata[flash_pkg::CB_START_N];
  wire hv_done = st_q == flash_pkg::ST_HV && ref_tick && cnt_inc >= pt_len;
  wire post_done = st_q == flash_pkg::ST_POST && post_q == 4'(WR_LAT - 1);
  wire [4:0] last_sect = waddr_q[12:8];
  wire [3:0] last_row = waddr_q[7:4];

  // Returns one where a high-voltage pulse may touch the sector
  function automatic logic writable(input logic [4:0] s);
    writable = !prot_q[s] && !LOCK_MASK[s];
  endfunction

  // ****************************************
  // Next-state selection
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      flash_pkg::ST_IDLE: begin
        st_d = hv_start ? flash_pkg::ST_HV : ((mem_wr || replay) ? flash_pkg::ST_POST : flash_pkg::ST_IDLE);
      end
      flash_pkg::ST_POST: begin
        st_d = post_done ? flash_pkg::ST_IDLE : flash_pkg::ST_POST;
      end
      flash_pkg::ST_HV: begin
        st_d = hv_done ? flash_pkg::ST_IDLE : flash_pkg::ST_HV;
      end
      default: begin
        st_d = flash_pkg::ST_IDLE;
      end
    endcase
  end

  // Control word: replay never stored, start bit only drops when a pulse really starts
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = bus.wdata[flash_pkg::CTRL_W-1:0];
      ctrl_d[flash_pkg::CB_REPLAY] = 1'b0;
      ctrl_d[flash_pkg::CB_START_N] = !hv_start;
    end
    if (hv_done) begin
      ctrl_d[flash_pkg::CB_START_N] = 1'b1;
      ctrl_d[flash_pkg::CB_ERASE_PAGE] = 1'b0;
    end
  end

  // Interrupt bits: hardware set wins over a clear in the same cycle
  wire [flash_pkg::INT_W-1:0] wmask = bus.wdata[flash_pkg::INT_W-1:0];
  wire [flash_pkg::INT_W-1:0] st_clr = reg_wr && ofs == flash_pkg::OFS_INT_CLR_ST ? wmask : 4'h0;
  wire [flash_pkg::INT_W-1:0] st_set = reg_wr && ofs == flash_pkg::OFS_INT_SET_ST ? wmask : 4'h0;
  wire [flash_pkg::INT_W-1:0] en_clr = reg_wr && ofs == flash_pkg::OFS_INT_CLR_EN ? wmask : 4'h0;
  wire [flash_pkg::INT_W-1:0] en_set = reg_wr && ofs == flash_pkg::OFS_INT_SET_EN ? wmask : 4'h0;
  always_comb begin
    int_st_d = (int_st_q & ~st_clr) | st_set;
    int_st_d[flash_pkg::INT_DONE_BIT] = int_st_d[flash_pkg::INT_DONE_BIT] | hv_done;
    int_en_d = (int_en_q & ~en_clr) | en_set;
  end

  // Register read mux; unmapped offsets read zero
  wire [31:0] reg_rd = ofs == flash_pkg::OFS_CTRL ? {23'h000000, ctrl_q} :
                       ofs == flash_pkg::OFS_STATE ? {31'h00000000, array_ready_out} :
                       ofs == flash_pkg::OFS_PTIME ? {15'h0000, ptime_q} :
                       ofs == flash_pkg::OFS_INT_STATUS ? {28'h0000000, int_st_q} :
                       ofs == flash_pkg::OFS_INT_ENABLE ? {28'h0000000, int_en_q} : 32'h00000000;

  // ****************************************
  // Control flops
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= flash_pkg::ST_IDLE;
      ctrl_q <= flash_pkg::CTRL_RESET;
      ptime_q <= flash_pkg::PTIME_RESET;
      int_st_q <= flash_pkg::INT_RESET;
      int_en_q <= flash_pkg::INT_RESET;
      irq_out <= 1'b0;
      array_ready_out <= 1'b1;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= 16'h0000;
      post_q <= 4'h0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      int_st_q <= int_st_d;
      int_en_q <= int_en_d;
      irq_out <= |(int_st_d & int_en_d);
      array_ready_out <= st_d != flash_pkg::ST_HV;
      ack_q <= ack_d;
      err_q <= mem_err;
      ref_s1_q <= timing_ref_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      if (reg_wr && ofs == flash_pkg::OFS_PTIME) begin
        ptime_q <= bus.wdata[flash_pkg::PT_LEN_W:0];
      end
      cnt_q <= hv_start ? 16'h0000 : (st_q == flash_pkg::ST_HV && ref_tick ? cnt_inc : cnt_q);
      post_q <= st_q == flash_pkg::ST_POST ? post_q + 4'h1 : 4'h0;
    end
  end

  // Protection and erase selection live in the array; all sectors start protected
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prot_q <= {flash_pkg::SECT_N{1'b1}};
      sel_q <= {flash_pkg::SECT_N{1'b0}};
      waddr_q <= 13'h0000;
      wdata_q <= 32'h00000000;
    end else begin
      if (mem_wr) begin
        waddr_q <= word_idx;
        wdata_q <= bus.wdata;
      end
      if (post_done && enable && op_sel && !variant) begin
        sel_q[last_sect] <= 1'b1;
      end
      if (post_done && enable && op_sel && variant) begin
        prot_q[last_sect] <= wdata_q[0];
      end
      if (hv_done && !variant) begin
        sel_q <= {flash_pkg::SECT_N{1'b0}};
      end
    end
  end

  // ****************************************
  // Array and page buffer
  // ****************************************
  // Data storage has no reset; software presets the buffer before use
  always_ff @(posedge ref_clk_in) begin
    if (mem_rd) begin
      rdata_q <= mem_q[word_idx];
    end else if (reg_take && !bus.we) begin
      rdata_q <= reg_rd;
    end
    for (int w = 0; w < flash_pkg::ROW_WORDS; w++) begin
      if (ctrl_q[flash_pkg::CB_PRESET]) begin
        pbuf_q[w] <= {flash_pkg::DATA_W{1'b1}};
      end else if (post_done && enable && !op_sel && variant && waddr_q[3:0] == 4'(w)) begin
        pbuf_q[w] <= wdata_q;
      end
    end
    // Skipped sectors give no error, as the array keeps protection itself
    if (hv_done && !variant) begin
      for (int i = 0; i < flash_pkg::WORDS; i++) begin
        if (writable(5'(i / 256)) && (ctrl_q[flash_pkg::CB_ERASE_PAGE] ?
            (5'(i / 256) == last_sect && 4'((i / 16) % 16) == last_row) :
            (sel_q[i / 256] || 5'(i / 256) == last_sect))) begin
          mem_q[i] <= {flash_pkg::DATA_W{1'b1}};
        end
      end
    end
    if (hv_done && variant && writable(last_sect)) begin
      for (int w = 0; w < flash_pkg::ROW_WORDS; w++) begin
        mem_q[{last_sect, last_row, 4'(w)}] <= mem_q[{last_sect, last_row, 4'(w)}] & pbuf_q[w];
      end
    end
  end

endmodule

// [rtl/flash_pkg.sv]
package flash_pkg;

  // ****************************************
  // Geometry and bus widths
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int SECT_N = 32;
  localparam int ROW_N = 16;
  localparam int ROW_WORDS = 16;
  localparam int WORDS = SECT_N * ROW_N * ROW_WORDS;
  localparam int REG_SPACE_BIT = 15;

  // ****************************************
  // Device register offsets
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATE = 12'h004;
  localparam logic [11:0] OFS_PTIME = 12'h008;
  localparam logic [11:0] OFS_INT_CLR_EN = 12'hFD8;
  localparam logic [11:0] OFS_INT_SET_EN = 12'hFDC;
  localparam logic [11:0] OFS_INT_STATUS = 12'hFE0;
  localparam logic [11:0] OFS_INT_ENABLE = 12'hFE4;
  localparam logic [11:0] OFS_INT_CLR_ST = 12'hFE8;
  localparam logic [11:0] OFS_INT_SET_ST = 12'hFEC;

  // ****************************************
  // Control word fields and reset values
  // ****************************************
  localparam int CTRL_W = 9;
  localparam int CB_ENABLE = 0;
  localparam int CB_VARIANT = 1;
  localparam int CB_START_N = 2;
  localparam int CB_ERASE_PAGE = 5;
  localparam int CB_PRESET = 6;
  localparam int CB_REPLAY = 7;
  localparam int CB_OP_SEL = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h005;
  localparam int PT_LEN_W = 16;
  localparam int PT_EN_BIT = 16;
  localparam logic [PT_LEN_W:0] PTIME_RESET = 17'h00000;
  localparam int ST_READY_BIT = 0;
  localparam int INT_W = 4;
  localparam int INT_DONE_BIT = 2;
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;

  // ****************************************
  // Host command port
  // ****************************************
  localparam logic [2:0] H_ADDR = 3'h0;
  localparam logic [2:0] H_WDATA = 3'h1;
  localparam logic [2:0] H_CMD = 3'h2;
  localparam logic [2:0] H_RDATA = 3'h3;
  localparam logic [2:0] H_STATUS = 3'h4;
  localparam int HCMD_GO = 0;
  localparam int HCMD_WRITE = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POST = 2'b01,
    ST_HV = 2'b11
  } arr_state_t;

endpackage

// [rtl/flash_bus_if.sv]
`timescale 1ns/10ps
interface flash_bus_if;
  logic req;
  logic we;
  logic [flash_pkg::ADDR_W-1:0] addr;
  logic [flash_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic err;
  logic [flash_pkg::DATA_W-1:0] rdata;

  modport host (output req, output we, output addr, output wdata, input ack, input err, input rdata);
  modport dev (input req, input we, input addr, input wdata, output ack, output err, output rdata);
endinterface

// [rtl/flash_host_end.sv]
`timescale 1ns/10ps
module flash_host_end (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] cmd_addr_in,
  input wire logic [31:0] cmd_wdata_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  output logic [31:0] cmd_rdata_out,
  flash_bus_if.host bus
);

  // ****************************************
  // Command decode
  // ****************************************
  logic [flash_pkg::ADDR_W-1:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic req_q;
  logic we_q;
  logic err_q;
  logic done_q;
  wire go = cmd_wr_in && cmd_addr_in == flash_pkg::H_CMD && cmd_wdata_in[flash_pkg::HCMD_GO] && !req_q;
  wire [31:0] status = {29'h0000000, done_q, err_q, req_q};
  wire [31:0] rd_mux = cmd_addr_in == flash_pkg::H_ADDR ? {16'h0000, addr_q} :
                       cmd_addr_in == flash_pkg::H_WDATA ? wdata_q :
                       cmd_addr_in == flash_pkg::H_RDATA ? rdata_q :
                       cmd_addr_in == flash_pkg::H_STATUS ? status : 32'h00000000;

  // Bus signals come straight from the request flops
  assign bus.req = req_q;
  assign bus.we = we_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;

  // ****************************************
  // Request holding
  // ****************************************
  // One transfer at a time; GO while busy is dropped so software polls status first
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      req_q <= 1'b0;
      we_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      cmd_rdata_out <= 32'h00000000;
    end else begin
      cmd_rdata_out <= cmd_rd_in ? rd_mux : 32'h00000000;
      if (cmd_wr_in && cmd_addr_in == flash_pkg::H_ADDR) begin
        addr_q <= cmd_wdata_in[flash_pkg::ADDR_W-1:0];
      end
      if (cmd_wr_in && cmd_addr_in == flash_pkg::H_WDATA) begin
        wdata_q <= cmd_wdata_in;
      end
      if (go) begin
        req_q <= 1'b1;
        we_q <= cmd_wdata_in[flash_pkg::HCMD_WRITE];
        done_q <= 1'b0;
        err_q <= 1'b0;
      end else if (req_q && bus.ack) begin
        req_q <= 1'b0;
        done_q <= 1'b1;
        err_q <= bus.err;
        if (!we_q) begin
          rdata_q <= bus.rdata;
        end
      end
    end
  end

endmodule

// [sim/flash_bus_sva.sv]
`timescale 1ns/10ps
// ****************************************
// Bus and status checks
// ****************************************
module flash_bus_sva #(
  parameter int unsigned WR_LAT = 2
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req,
  input wire logic we,
  input wire logic [flash_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_pkg::DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic array_ready_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Cycles since the last answer; saturates so a long quiet spell still reads as idle
  logic [4:0] quiet_q;
  logic [4:0] quiet_d;
  assign quiet_d = ack ? 5'h00 : ((quiet_q == 5'h1F) ? quiet_q : quiet_q + 5'h01);

  // Starts saturated, since no posted write can be pending after reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_q <= 5'h1F;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  chk_ack_single: assert property (ack |=> !ack) else $error("answer longer than one cycle");
  chk_err_only_ack: assert property (err |-> ack) else $error("error without answer");
  chk_req_holds: assert property (req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata))
    else $error("request changed before answer");
  chk_req_drops: assert property (ack |=> !req) else $error("request kept after answer");
  chk_ack_bounded: assert property ($rose(req) |-> ##[1:40] ack) else $error("answer too late");
  chk_hv_error: assert property (req && !ack && !addr[15] && !array_ready_out ##1 !array_ready_out |-> ack && err)
    else $error("memory access during pulse not refused");
  chk_mem_ok_ready: assert property (ack && !err && !addr[15] |-> array_ready_out)
    else $error("memory access served while array busy");
  chk_reg_write_ok: assert property (ack && we && addr[15] |-> !err)
    else $error("register write refused");
  // Idle array must take a memory access without wait states
  chk_posted_fast: assert property ($rose(req) && !addr[15] && array_ready_out && quiet_q > WR_LAT + 2 |=> ack)
    else $error("idle array inserted wait states");
endmodule

// [sim/test_flash_bus_access_and_program_erase.sv]
`timescale 1ns/10ps
module test_flash_bus_access_and_program_erase;
  // ****************************************
  // Stimulus, design and checker
  // ****************************************
  localparam logic [15:0] CTRL_A = {4'h8, flash_pkg::OFS_CTRL};
  localparam logic [15:0] STATE_A = {4'h8, flash_pkg::OFS_STATE};
  localparam logic [15:0] PTIME_A = {4'h8, flash_pkg::OFS_PTIME};
  localparam logic [15:0] ISTAT_A = {4'h8, flash_pkg::OFS_INT_STATUS};
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] cmd_addr_in = 3'h0;
  logic [31:0] cmd_wdata_in = 32'h00000000;
  logic cmd_wr_in = 1'b0;
  logic cmd_rd_in = 1'b0;
  logic [31:0] cmd_rdata_out;
  logic irq_out;
  logic array_ready_out;
  logic [31:0] rd;
  logic e;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int low_cnt = 0;
  int mark = 0;

  flash_bus_if i_if();
  flash_host_end i_flash_host_end (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in), .cmd_rdata_out(cmd_rdata_out), .bus(i_if));
  flash_dev_end #(.WR_LAT(2)) i_flash_dev_end (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .timing_ref_in(1'b0),
    .irq_out(irq_out), .array_ready_out(array_ready_out), .bus(i_if));
  flash_bus_sva #(.WR_LAT(2)) i_flash_bus_sva (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req(i_if.req),
    .we(i_if.we), .addr(i_if.addr), .wdata(i_if.wdata), .ack(i_if.ack), .err(i_if.err),
    .array_ready_out(array_ready_out));

  always #4 ref_clk_in = ~ref_clk_in;

  // Cycle count for the hang limit, and busy cycles for timing the pulse
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (!array_ready_out) begin
      low_cnt <= low_cnt + 1;
    end
    if (cycles == 6000) begin
      fails++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command-port cycle; strobes are re-driven every cycle so none is assigned twice at once
  task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [31:0] d);
    cmd_wr_in <= w;
    cmd_rd_in <= r;
    cmd_addr_in <= a;
    cmd_wdata_in <= d;
    @(posedge ref_clk_in);
    #1;
  endtask

  // One device-bus transfer through the host end; returns read data and error flag
  task automatic bus(input logic [15:0] a, input logic [31:0] d, input logic w, output logic [31:0] r,
                     output logic er);
    int n;
    cyc(1'b1, 1'b0, flash_pkg::H_ADDR, {16'h0000, a});
    cyc(1'b1, 1'b0, flash_pkg::H_WDATA, d);
    cyc(1'b1, 1'b0, flash_pkg::H_CMD, {30'h00000000, w, 1'b1});
    for (n = 0; n < 100 && i_if.ack !== 1'b1; n++) begin
      cyc(1'b0, 1'b0, flash_pkg::H_STATUS, 32'h00000000);
    end
    cyc(1'b0, 1'b0, flash_pkg::H_STATUS, 32'h00000000);
    cyc(1'b0, 1'b1, flash_pkg::H_STATUS, 32'h00000000);
    er = cmd_rdata_out[1];
    cyc(1'b0, 1'b1, flash_pkg::H_RDATA, 32'h00000000);
    r = cmd_rdata_out;
    cyc(1'b0, 1'b0, flash_pkg::H_ADDR, 32'h00000000);
  endtask

  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    bus(a, d, 1'b1, rd, e);
  endtask

  task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    bus(a, 32'h00000000, 1'b0, rd, e);
    chk(what, exp, rd);
  endtask

  task automatic wait_ready();
    int n;
    for (n = 0; n < 1000 && array_ready_out !== 1'b1; n++) begin
      cyc(1'b0, 1'b0, flash_pkg::H_ADDR, 32'h00000000);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    chk("ready", 32'h00000001, {31'h0, array_ready_out});
    chk("irq", 32'h00000000, {31'h0, irq_out});
    rchk("ctrl", CTRL_A, {23'h0, flash_pkg::CTRL_RESET});
    rchk("state", STATE_A, 32'h00000001);
    rchk("ptime", PTIME_A, 32'h00000000);
    rchk("unmapped", 16'h800C, 32'h00000000);
    wreg({4'h8, flash_pkg::OFS_INT_SET_EN}, 32'h00000004);
    rchk("enable", {4'h8, flash_pkg::OFS_INT_ENABLE}, 32'h00000004);
    wreg(CTRL_A, 32'h00000087);
    rchk("replay", CTRL_A, 32'h00000007);
    // Unprotect sector 3, then a read in that setup must be refused
    wreg(CTRL_A, 32'h00000107);
    bus(16'h0C00, 32'h00000000, 1'b1, rd, e);
    chk("unprotect err", 32'h00000000, {31'h0, e});
    bus(16'h0C00, 32'h00000000, 1'b0, rd, e);
    chk("setup read err", 32'h00000001, {31'h0, e});
    // Page erase with a long pulse, probing the array while it runs
    wreg(PTIME_A, 32'h000100C8);
    wreg(CTRL_A, 32'h00000121);
    bus(16'h0C00, 32'h00000000, 1'b0, rd, e);
    chk("busy read err", 32'h00000001, {31'h0, e});
    bus(16'h0C08, 32'h00000000, 1'b1, rd, e);
    chk("busy write err", 32'h00000001, {31'h0, e});
    rchk("state busy", STATE_A, 32'h00000000);
    wait_ready();
    rchk("ctrl after erase", CTRL_A, 32'h00000105);
    rchk("done erase", ISTAT_A, 32'h00000004);
    chk("irq set", 32'h00000001, {31'h0, irq_out});
    wreg({4'h8, flash_pkg::OFS_INT_CLR_ST}, 32'h00000004);
    chk("irq clear", 32'h00000000, {31'h0, irq_out});
    wreg(CTRL_A, 32'h00000005);
    rchk("erased first", 16'h0C00, 32'hFFFFFFFF);
    rchk("erased last", 16'h0C3C, 32'hFFFFFFFF);
    // Preset the buffer, load one word, and see the array untouched
    wreg(CTRL_A, 32'h00000047);
    wreg(CTRL_A, 32'h00000007);
    bus(16'h0C04, 32'hA5A50F0F, 1'b1, rd, e);
    chk("load err", 32'h00000000, {31'h0, e});
    wreg(CTRL_A, 32'h00000005);
    rchk("array untouched", 16'h0C04, 32'hFFFFFFFF);
    // Program with a 20-cycle pulse
    wreg(PTIME_A, 32'h00010014);
    mark = low_cnt;
    wreg(CTRL_A, 32'h00000103);
    wait_ready();
    cyc(1'b0, 1'b0, flash_pkg::H_ADDR, 32'h00000000);
    chk("pulse", 32'h00000014, 32'(low_cnt - mark));
    rchk("ctrl after prog", CTRL_A, 32'h00000107);
    rchk("done prog", ISTAT_A, 32'h00000004);
    wreg(CTRL_A, 32'h00000005);
    rchk("preset kept", 16'h0C00, 32'hFFFFFFFF);
    rchk("programmed", 16'h0C04, 32'hA5A50F0F);
    chk("byte0", 32'h0000000F, {24'h0, rd[7:0]});
    // Latch protected sector 4, then sector 3 as latest address, and erase whole sectors
    wreg(CTRL_A, 32'h00000105);
    bus(16'h1000, 32'h00000000, 1'b1, rd, e);
    chk("select err", 32'h00000000, {31'h0, e});
    bus(16'h0FFC, 32'h00000000, 1'b1, rd, e);
    wreg(PTIME_A, 32'h00010008);
    wreg(CTRL_A, 32'h00000101);
    wait_ready();
    rchk("ctrl after sector erase", CTRL_A, 32'h00000105);
    wreg(CTRL_A, 32'h00000005);
    rchk("sector erased", 16'h0C04, 32'hFFFFFFFF);
    rchk("whole sector", 16'h0C40, 32'hFFFFFFFF);
    // Retain a word in read setup, replay it into the buffer, then program it
    wreg(CTRL_A, 32'h00000047);
    wreg(CTRL_A, 32'h00000005);
    bus(16'h0C08, 32'h5A5A5A5A, 1'b1, rd, e);
    wreg(CTRL_A, 32'h00000087);
    wreg(CTRL_A, 32'h00000103);
    wait_ready();
    // Protect sector 3 again; a later erase aimed at it is skipped without error
    wreg(CTRL_A, 32'h00000107);
    bus(16'h0C00, 32'h00000001, 1'b1, rd, e);
    chk("protect err", 32'h00000000, {31'h0, e});
    wreg(CTRL_A, 32'h00000101);
    wait_ready();
    wreg(CTRL_A, 32'h00000005);
    rchk("replayed and kept", 16'h0C08, 32'h5A5A5A5A);
    summarize();
  end
endmodule
